// ==== inc/lchp_pkg.sv ====
// Package for the LAN controller I/O-mode host port: address map, widths, timing.
// Assumes a single 100 MHz clock shared by both ends of the port.
package lchp_pkg;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned NUM_PORTS     = 8;
    localparam int unsigned PORT_W        = 16;
    localparam int unsigned UPPER_ADDR_W  = 6;
    localparam int unsigned FULL_ADDR_W   = ADDR_W + UPPER_ADDR_W;
    localparam logic [FULL_ADDR_W-1:0] BASE_ADDR = 10'h300;
    localparam logic [UPPER_ADDR_W-1:0] BASE_UPPER = BASE_ADDR[FULL_ADDR_W-1:ADDR_W];
    localparam logic [PORT_W-1:0] PORT_RESET  = 16'h0000;
    // Host strobe width and setup/hold, given in ns and rounded up to clock cycles
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SETUP_NS      = 20;
    localparam int unsigned STROBE_NS     = 60;
    localparam int unsigned SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 4;
    localparam logic [CNT_W-1:0] SETUP_CNT  = CNT_W'(SETUP_CYC);
    localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
    // Link rate fixed to ten megabits; 100 MHz / 10 = one bit time
    localparam int unsigned LINK_MBPS     = 10;
    localparam logic [3:0] BIT_CYC        = 4'(100 / LINK_MBPS);
endpackage

// ==== inc/lchp_if.sv ====
// Interface joining the host and the controller over the I/O-mode port.
// Data is an 8-bit two-way bus; each end drives only while its enable is low.
`timescale 1ns/10ps
interface lchp_if;
    logic [lchp_pkg::FULL_ADDR_W-1:0] addr;
    logic                             read_strobe_n;
    logic                             write_strobe_n;
    logic [lchp_pkg::DATA_W-1:0]      host_data_o;
    logic                             host_data_oe_n;
    logic [lchp_pkg::DATA_W-1:0]      dev_data_o;
    logic                             dev_data_oe_n;
    logic [lchp_pkg::DATA_W-1:0]      data_i;
    logic                             lan_reset;
    logic                             activity_indicator_n;
    logic                             link_indicator;
    logic                             link_rate_10m;

    // Resolved level of the shared data bus
    assign data_i = !dev_data_oe_n ? dev_data_o
                  : (!host_data_oe_n ? host_data_o : '1);

    modport host (
        output addr,
        output read_strobe_n,
        output write_strobe_n,
        output host_data_o,
        output host_data_oe_n,
        input  data_i,
        output lan_reset,
        input  activity_indicator_n,
        input  link_indicator,
        input  link_rate_10m
    );
    modport dev (
        input  addr,
        input  read_strobe_n,
        input  write_strobe_n,
        output dev_data_o,
        output dev_data_oe_n,
        input  data_i,
        input  lan_reset,
        output activity_indicator_n,
        output link_indicator,
        output link_rate_10m
    );
endinterface

// ==== rtl/lchp_dev.sv ====
// Controller end of the I/O-mode host port: eight 16-bit ports at the fixed base.
// Assumes all port pins come from another domain; user side is on mclk.
//
// Summary of operation
// - I/O-space mode always on, no setup
// - Port carries bytes on 8-bit bus
// - Eight 16-bit ports, sixteen byte addresses
// - Active-low read and write strobes
// - Decode at base address after reset
// - Host holds upper address at base
// - Address first, data from strobe start until hold ends
// - Controller reset input active high
// - Activity indicator low during frame traffic
// - Link indicator on with link pulses
// - Link fixed at ten megabits
`timescale 1ns/10ps
module lchp_dev #(
    parameter int unsigned NUM_PORTS = lchp_pkg::NUM_PORTS
) (
    input  wire logic                          mclk,
    input  wire logic                          rstn,
    lchp_if.dev                                bus,
    input  wire logic                          tx_busy,
    input  wire logic                          rx_busy,
    input  wire logic                          link_pulse_ok,
    input  wire logic [NUM_PORTS*lchp_pkg::PORT_W-1:0] port_rd_data,
    output logic      [NUM_PORTS*lchp_pkg::PORT_W-1:0] port_wr_data,
    output logic      [NUM_PORTS-1:0]          port_wr_stb,
    output logic      [NUM_PORTS-1:0]          port_rd_stb
);
    localparam int unsigned AW = lchp_pkg::FULL_ADDR_W;
    localparam int unsigned DW = lchp_pkg::DATA_W;
    localparam int unsigned PW = lchp_pkg::PORT_W;
    localparam int unsigned SW = $clog2(NUM_PORTS);

    // The low address is three port bits and one byte bit, so the map is fixed
    if (NUM_PORTS != 8)
    begin
        $error("lchp_dev: port count must be eight");
    end
    if (PW != 2 * DW)
    begin
        $error("lchp_dev: a port must be two bus bytes wide");
    end
    if (lchp_pkg::ADDR_W != SW + 1)
    begin
        $error("lchp_dev: low address must hold port and byte select");
    end

    typedef enum {DEV_IDLE, DEV_WRITE, DEV_READ} lchp_dev_phase_type;

    typedef struct packed {
        lchp_dev_phase_type           phase;
        logic [1:0][AW-1:0]           addr_sync;
        logic [1:0]                   rd_sync;
        logic [1:0]                   wr_sync;
        logic [1:0][DW-1:0]           din_sync;
        logic [1:0]                   rst_sync;
        logic [NUM_PORTS*PW-1:0]      wr_data;
        logic [NUM_PORTS-1:0]         wr_stb;
        logic [NUM_PORTS-1:0]         rd_stb;
        logic [DW-1:0]                dout;
        logic                         oe_n;
        logic                         act_n;
        logic                         link;
    } lchp_dev_state_type;

    // Idle levels: strobes seen high, bus released, no traffic shown
    localparam lchp_dev_state_type RST_STATE = '{
        phase:   DEV_IDLE,
        rd_sync: '1,
        wr_sync: '1,
        wr_data: {NUM_PORTS{lchp_pkg::PORT_RESET}},
        oe_n:    1'b1,
        act_n:   1'b1,
        default: '0
    };

    lchp_dev_state_type cur_ff;
    lchp_dev_state_type nxt_cur;

    function automatic logic hit(input logic [AW-1:0] a);
        hit = (a[AW-1:lchp_pkg::ADDR_W] == lchp_pkg::BASE_UPPER);
    endfunction

    // Bit offset of one byte lane in the flat port bus; the low byte sits at the even address
    function automatic int unsigned lane(input logic [SW-1:0] sel, input logic hi);
        lane = int'(sel) * PW + (hi ? DW : 0);
    endfunction

    logic [AW-1:0]        a_s;
    logic [SW-1:0]        port_sel;
    logic                 hi_byte;
    logic                 in_reset;
    logic                 rd_low;
    logic                 wr_low;
    logic                 addr_hit;
    int unsigned          lane_lo;

    always_comb
    begin
        nxt_cur  = cur_ff;
        a_s      = cur_ff.addr_sync[1];
        port_sel = a_s[lchp_pkg::ADDR_W-1:1];
        hi_byte  = a_s[0];
        in_reset = cur_ff.rst_sync[1];
        rd_low   = !cur_ff.rd_sync[1];
        wr_low   = !cur_ff.wr_sync[1];
        addr_hit = hit(a_s);
        lane_lo  = lane(port_sel, hi_byte);

        // Address, strobes and data share one delay, so they stay aligned to each other
        nxt_cur.addr_sync = {cur_ff.addr_sync[0], bus.addr};
        nxt_cur.rd_sync   = {cur_ff.rd_sync[0], bus.read_strobe_n};
        nxt_cur.wr_sync   = {cur_ff.wr_sync[0], bus.write_strobe_n};
        nxt_cur.din_sync  = {cur_ff.din_sync[0], bus.data_i};
        nxt_cur.rst_sync  = {cur_ff.rst_sync[0], bus.lan_reset};
        nxt_cur.wr_stb    = '0;
        nxt_cur.rd_stb    = '0;
        nxt_cur.oe_n      = 1'b1;
        // I/O mode needs no enable; decode is live straight out of reset
        if (in_reset)
        begin
            // Held in reset the ports fall back to their reset words
            nxt_cur.phase   = DEV_IDLE;
            nxt_cur.wr_data = {NUM_PORTS{lchp_pkg::PORT_RESET}};
        end
        else
        begin
            unique case (cur_ff.phase)
                DEV_IDLE:
                begin
                    // A foreign base or two strobes low at once is not answered
                    if (rd_low && !wr_low && addr_hit)
                    begin
                        nxt_cur.phase = DEV_READ;
                        nxt_cur.oe_n  = 1'b0;
                        nxt_cur.dout  = port_rd_data[lane_lo +: DW];
                        if (hi_byte)
                        begin
                            nxt_cur.rd_stb[port_sel] = 1'b1;
                        end
                    end
                    else if (wr_low && !rd_low && addr_hit)
                    begin
                        nxt_cur.phase = DEV_WRITE;
                    end
                end
                DEV_WRITE:
                begin
                    // Byte is latched as the strobe rises; the host still drives it then
                    if (!wr_low)
                    begin
                        nxt_cur.phase = DEV_IDLE;
                        nxt_cur.wr_data[lane_lo +: DW] = cur_ff.din_sync[1];
                        if (hi_byte)
                        begin
                            nxt_cur.wr_stb[port_sel] = 1'b1;
                        end
                    end
                end
                DEV_READ:
                begin
                    // Drive follows the strobe and is dropped as soon as it rises
                    if (rd_low && !wr_low && addr_hit)
                    begin
                        nxt_cur.oe_n = 1'b0;
                        nxt_cur.dout = port_rd_data[lane_lo +: DW];
                    end
                    else
                    begin
                        nxt_cur.phase = DEV_IDLE;
                    end
                end
                default:
                begin
                    nxt_cur.phase = DEV_IDLE;
                end
            endcase
        end

        // Indicators stay quiet while the controller is held in reset
        nxt_cur.act_n = in_reset || !(tx_busy || rx_busy);
        nxt_cur.link  = !in_reset && link_pulse_ok;

        if (!rstn)
        begin
            nxt_cur = RST_STATE;
        end
    end

    always_ff @(posedge mclk)
    begin
        cur_ff <= nxt_cur;
    end

    assign bus.dev_data_o           = cur_ff.dout;
    assign bus.dev_data_oe_n        = cur_ff.oe_n;
    assign bus.activity_indicator_n = cur_ff.act_n;
    assign bus.link_indicator       = cur_ff.link;
    assign bus.link_rate_10m        = 1'b1;
    assign port_wr_data             = cur_ff.wr_data;
    assign port_wr_stb              = cur_ff.wr_stb;
    assign port_rd_stb              = cur_ff.rd_stb;
endmodule

// ==== rtl/lchp_host.sv ====
// Host end of the port: runs byte reads and writes on request.
// Assumes the user holds a request until done pulses; one access at a time.
`timescale 1ns/10ps
module lchp_host (
    input  wire logic                            mclk,
    input  wire logic                            rstn,
    lchp_if.host                                 bus,
    input  wire logic                            req,
    input  wire logic                            req_write,
    input  wire logic [lchp_pkg::ADDR_W-1:0]     req_addr,
    input  wire logic [lchp_pkg::DATA_W-1:0]     req_wdata,
    input  wire logic                            lan_reset_req,
    output logic                                 done,
    output logic      [lchp_pkg::DATA_W-1:0]     rdata,
    output logic                                 activity,
    output logic                                 link_up
);
    typedef enum {IDLE, SETUP, STROBE, HOLD} lchp_hst_type;

    typedef struct packed {
        lchp_hst_type                         st;
        logic [lchp_pkg::CNT_W-1:0]           cnt;
        logic [lchp_pkg::ADDR_W-1:0]          addr;
        logic [lchp_pkg::DATA_W-1:0]          wdata;
        logic                                 wr;
        logic                                 rd_n;
        logic                                 wr_n;
        logic                                 oe_n;
        logic                                 done;
        logic [lchp_pkg::DATA_W-1:0]          rdata;
        logic [1:0]                           act_sync;
        logic [1:0]                           link_sync;
        logic [1:0][lchp_pkg::DATA_W-1:0]     din_sync;
        logic                                 lan_rst;
        logic                                 act;
    } lchp_host_state_type;

    lchp_host_state_type cur_ff;
    lchp_host_state_type nxt_cur;

    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.done      = 1'b0;
        nxt_cur.act_sync  = {cur_ff.act_sync[0], bus.activity_indicator_n};
        nxt_cur.link_sync = {cur_ff.link_sync[0], bus.link_indicator};
        nxt_cur.din_sync  = {cur_ff.din_sync[0], bus.data_i};
        nxt_cur.lan_rst   = lan_reset_req;
        nxt_cur.act       = !cur_ff.act_sync[1];
        unique case (cur_ff.st)
            IDLE:
            begin
                if (req && !cur_ff.done)
                begin
                    nxt_cur.addr  = req_addr;
                    nxt_cur.wdata = req_wdata;
                    nxt_cur.wr    = req_write;
                    nxt_cur.cnt   = lchp_pkg::SETUP_CNT;
                    nxt_cur.st    = SETUP;
                end
            end
            SETUP:
            begin
                nxt_cur.cnt = cur_ff.cnt - 1'b1;
                if (cur_ff.cnt == 1)
                begin
                    // Only one strobe ever goes low
                    nxt_cur.rd_n = cur_ff.wr;
                    nxt_cur.wr_n = !cur_ff.wr;
                    nxt_cur.oe_n = !cur_ff.wr;
                    nxt_cur.cnt  = lchp_pkg::STROBE_CNT;
                    nxt_cur.st   = STROBE;
                end
            end
            STROBE:
            begin
                nxt_cur.cnt = cur_ff.cnt - 1'b1;
                if (cur_ff.cnt == 1)
                begin
                    nxt_cur.rdata = cur_ff.din_sync[1];
                    nxt_cur.rd_n  = 1'b1;
                    nxt_cur.wr_n  = 1'b1;
                    nxt_cur.cnt   = lchp_pkg::SETUP_CNT;
                    nxt_cur.st    = HOLD;
                end
            end
            HOLD:
            begin
                // Address and write data held past the strobe edge
                nxt_cur.cnt = cur_ff.cnt - 1'b1;
                if (cur_ff.cnt == 1)
                begin
                    nxt_cur.oe_n = 1'b1;
                    nxt_cur.done = 1'b1;
                    nxt_cur.st   = IDLE;
                end
            end
            default:
                nxt_cur.st = IDLE;
        endcase
        if (!rstn)
        begin
            nxt_cur = '0;
            nxt_cur.st   = IDLE;
            nxt_cur.rd_n = 1'b1;
            nxt_cur.wr_n = 1'b1;
            nxt_cur.oe_n = 1'b1;
            nxt_cur.act_sync = '1;
        end
    end

    always_ff @(posedge mclk)
    begin
        cur_ff <= nxt_cur;
    end

    assign bus.addr           = {lchp_pkg::BASE_UPPER, cur_ff.addr};
    assign bus.read_strobe_n  = cur_ff.rd_n;
    assign bus.write_strobe_n = cur_ff.wr_n;
    assign bus.host_data_o    = cur_ff.wdata;
    assign bus.host_data_oe_n = cur_ff.oe_n;
    assign bus.lan_reset      = cur_ff.lan_rst;
    assign done               = cur_ff.done;
    assign rdata              = cur_ff.rdata;
    assign activity           = cur_ff.act;
    assign link_up            = cur_ff.link_sync[1];
endmodule

// ==== sim/lchp_checker.sv ====
// Checker for the wires between host end and controller end of the port.
// Assumes one clock domain; instantiated by the bench top beside the interface.
`timescale 1ns/10ps
module lchp_checker (
    input wire logic                             mclk,
    input wire logic                             rstn,
    input wire logic [lchp_pkg::FULL_ADDR_W-1:0] addr,
    input wire logic                             read_strobe_n,
    input wire logic                             write_strobe_n,
    input wire logic                             host_data_oe_n,
    input wire logic                             dev_data_oe_n,
    input wire logic                             lan_reset,
    input wire logic                             link_rate_10m
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    strobe_excl_a: assert property (!(!read_strobe_n && !write_strobe_n))
        else $error("both strobes low together");
    addr_base_a: assert property (!(read_strobe_n && write_strobe_n) |->
        addr[lchp_pkg::FULL_ADDR_W-1:lchp_pkg::ADDR_W] == lchp_pkg::BASE_UPPER)
        else $error("upper address off base during access");
    addr_setup_a: assert property ($fell(write_strobe_n) |-> $past(addr, 2) == addr)
        else $error("address not set up before write strobe");
    rd_width_a: assert property ($fell(read_strobe_n) |->
        !read_strobe_n [*6] ##1 read_strobe_n)
        else $error("read strobe width wrong");
    dev_answer_a: assert property ($fell(read_strobe_n) && !lan_reset |->
        ##[1:4] !dev_data_oe_n)
        else $error("controller did not drive read data");
    dev_release_a: assert property (read_strobe_n [*5] |-> dev_data_oe_n)
        else $error("controller drives bus outside read");
    no_fight_a: assert property (!(!dev_data_oe_n && !host_data_oe_n))
        else $error("both ends drive data bus");
    host_wdata_a: assert property ($fell(write_strobe_n) |-> !host_data_oe_n)
        else $error("host not driving during write strobe");
    reset_quiet_a: assert property (lan_reset [*4] |-> dev_data_oe_n)
        else $error("controller drives bus while held in reset");
    rate_fixed_a: assert property (link_rate_10m)
        else $error("link rate not fixed low speed");

    cover property ($fell(write_strobe_n));
    cover property ($fell(read_strobe_n) ##[1:4] !dev_data_oe_n);
    cover property (lan_reset [*4]);
endmodule

// ==== sim/lan_ctrl_io_mode_host_port_tb_top.sv ====
// Bench top: host end and controller end joined by the interface.
// Assumes a 100 MHz clock; scoreboard queues hold expected read bytes and port words.
`timescale 1ns/10ps
`define CHK(got, exp, msg) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp); \
        end \
    end
module lan_ctrl_io_mode_host_port_tb_top;
    logic         mclk = 1'b0;
    logic         rstn, req, req_write, lan_reset_req, done, activity, link_up;
    logic         tx_busy, rx_busy, link_pulse_ok;
    logic [3:0]   req_addr;
    logic [7:0]   req_wdata, rdata, exp_b;
    logic [127:0] port_rd_data, port_wr_data, rd_all;
    logic [7:0]   port_wr_stb, port_rd_stb;
    logic [31:0]  seed, w;
    logic [18:0]  exp_w;
    logic [7:0]   rd_q[$];
    logic [18:0]  wr_q[$];
    logic [2:0]   rs_q[$];
    logic [2:0]   exp_p;
    int           n_fail = 0;
    int           total_checks = 0;
    int           cyc = 0;

    always #5 mclk = ~mclk;

    lchp_if bus_if ();
    lchp_host lchp_host_inst (.mclk(mclk), .rstn(rstn), .bus(bus_if), .req(req),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .lan_reset_req(lan_reset_req), .done(done), .rdata(rdata),
        .activity(activity), .link_up(link_up));
    lchp_dev lchp_dev_inst (.mclk(mclk), .rstn(rstn), .bus(bus_if), .tx_busy(tx_busy),
        .rx_busy(rx_busy), .link_pulse_ok(link_pulse_ok), .port_rd_data(port_rd_data),
        .port_wr_data(port_wr_data), .port_wr_stb(port_wr_stb), .port_rd_stb(port_rd_stb));
    lchp_checker lchp_checker_inst (.mclk(mclk), .rstn(rstn), .addr(bus_if.addr),
        .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
        .host_data_oe_n(bus_if.host_data_oe_n), .dev_data_oe_n(bus_if.dev_data_oe_n),
        .lan_reset(bus_if.lan_reset), .link_rate_10m(bus_if.link_rate_10m));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Request held until done is seen, dropped in the done cycle
    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        req <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (done !== 1'b1 && n < 40);
        `CHK(done, 1'b1, "access never completed")
        req <= 1'b0;
    endtask

    // Scoreboard side: results are matched to the oldest note
    always @(posedge mclk)
    begin
        if (rstn === 1'b1 && done === 1'b1 && req_write === 1'b0)
        begin
            exp_b = rd_q.pop_front();
            `CHK(rdata, exp_b, "read byte")
        end
        if (rstn === 1'b1 && port_wr_stb !== 8'h00)
        begin
            exp_w = wr_q.pop_front();
            `CHK(port_wr_stb, 8'h01 << exp_w[18:16], "write strobe")
            `CHK(port_wr_data[16*int'(exp_w[18:16]) +: 16], exp_w[15:0], "port word")
        end
        if (rstn === 1'b1 && port_rd_stb !== 8'h00)
        begin
            exp_p = rs_q.pop_front();
            `CHK(port_rd_stb, 8'h01 << exp_p, "read strobe")
        end
    end

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_fail++;
            $display("[ERR] %0t run did not finish in time", $time);
            test_done();
        end
    end

    initial
    begin
        rstn = 1'b0;
        req = 1'b0;
        req_write = 1'b0;
        req_addr = 4'h0;
        req_wdata = 8'h00;
        lan_reset_req = 1'b0;
        {tx_busy, rx_busy, link_pulse_ok} = 3'b000;
        seed = 32'h0000_06ee;
        rd_all = {rnd(), rnd(), rnd(), rnd()};
        port_rd_data = rd_all;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        // Low byte first; the high byte commits the word
        for (int k = 0; k < 8; k++)
        begin
            w = rnd();
            wr_q.push_back({3'(k), w[15:0]});
            access(1'b1, 4'(2*k), w[7:0]);
            access(1'b1, 4'(2*k+1), w[15:8]);
        end
        $display("test port writes finished");
        for (int k = 0; k < 8; k++)
        begin
            rd_q.push_back(rd_all[16*k +: 8]);
            rd_q.push_back(rd_all[16*k+8 +: 8]);
            rs_q.push_back(3'(k));
            access(1'b0, 4'(2*k), 8'h00);
            access(1'b0, 4'(2*k+1), 8'h00);
        end
        $display("test port reads finished");
        @(posedge mclk);
        lan_reset_req <= 1'b1;
        repeat (8) @(posedge mclk);
        `CHK(bus_if.lan_reset, 1'b1, "reset pin level")
        `CHK(port_wr_data, 128'h0, "ports after reset")
        // A read while held in reset finds the bus released and idle high
        rd_q.push_back(8'hff);
        access(1'b0, 4'h1, 8'h00);
        lan_reset_req <= 1'b0;
        repeat (4) @(posedge mclk);
        w = rnd();
        wr_q.push_back({3'd6, w[15:0]});
        access(1'b1, 4'hc, w[7:0]);
        access(1'b1, 4'hd, w[15:8]);
        $display("test controller reset finished");
        for (int m = 0; m < 8; m++)
        begin
            @(posedge mclk);
            {tx_busy, rx_busy, link_pulse_ok} <= 3'(m);
            repeat (8) @(posedge mclk);
            `CHK(bus_if.activity_indicator_n, ~(tx_busy | rx_busy), "activity pin")
            `CHK(activity, tx_busy | rx_busy, "activity seen")
            `CHK(bus_if.link_indicator, link_pulse_ok, "link pin")
            `CHK(link_up, link_pulse_ok, "link seen")
            `CHK(bus_if.link_rate_10m, 1'b1, "link rate")
        end
        $display("test indicators finished");
        repeat (4) @(posedge mclk);
        `CHK(rd_q.size() + wr_q.size() + rs_q.size(), 0, "results missing")
        test_done();
    end
endmodule
